/* File: design/ocpi_channel_image.sv */
// Process image of one overcurrent channel: command word in, status word out.
// Assumes cmd_image is sampled once per clock while the link runs, and that
// the protection core supplies its status flags synchronously to clock.
module ocpi_channel_image (
   input wire logic clock,
   input wire logic reset,
   input wire logic link_running,
   input wire logic cmd_valid,
   input wire logic [15:0] cmd_image,
   input wire logic [15:0] out_assign_req,
   input wire logic [15:0] in_assign_req,
   input wire logic st_enabled,
   input wire logic st_tripped,
   input wire logic st_hw_protection,
   input wire logic st_current_warning,
   input wire logic st_cool_down_lock,
   input wire logic st_diag,
   input wire logic st_error,
   output logic [31:0] status_image,
   output logic [15:0] out_assign,
   output logic [15:0] in_assign,
   output logic channel_turn_on_pulse,
   output logic channel_reset_pulse
);
   typedef struct packed {
      logic rst_latch;
      logic on_latch;
      logic [1:0] cycle_cnt;
      logic tx_valid;
      logic [15:0] out_assign;
      logic [15:0] in_assign;
      logic [31:0] status;
      logic on_pulse;
      logic rst_pulse;
   } ocpi_state_s;

   ocpi_state_s st_r;
   ocpi_state_s st_nxt;

   // Every status bit outside the documented flags, counter and mirrors
   localparam logic [31:0] OCPI_STS_PAD_MASK = 32'hFFE3_0E6C;

   always_comb begin
      st_nxt = st_r;
      st_nxt.on_pulse = 1'b0;
      st_nxt.rst_pulse = 1'b0;
      if (!link_running) begin
         st_nxt.out_assign = out_assign_req;
         st_nxt.in_assign = in_assign_req;
         st_nxt.tx_valid = 1'b0;
      end
      if (link_running && cmd_valid) begin
         st_nxt.tx_valid = 1'b1;
         st_nxt.cycle_cnt = st_r.cycle_cnt + ocpi_pkg::OCPI_CNT_ONE;
         st_nxt.rst_latch = cmd_image[ocpi_pkg::CMD_RESET_BIT];
         st_nxt.on_latch = cmd_image[ocpi_pkg::CMD_ON_BIT];
         st_nxt.on_pulse = cmd_image[ocpi_pkg::CMD_ON_BIT] & ~st_r.on_latch;
         st_nxt.rst_pulse = cmd_image[ocpi_pkg::CMD_RESET_BIT] & ~st_r.rst_latch;
      end
      st_nxt.status = ocpi_pkg::OCPI_STS_RESET_VAL;
      st_nxt.status[ocpi_pkg::STS_ENABLED_BIT] = st_enabled;
      st_nxt.status[ocpi_pkg::STS_TRIPPED_BIT] = st_tripped;
      st_nxt.status[ocpi_pkg::STS_HWPROT_BIT] = st_hw_protection;
      st_nxt.status[ocpi_pkg::STS_WARN_BIT] = st_current_warning;
      st_nxt.status[ocpi_pkg::STS_COOL_BIT] = st_cool_down_lock;
      st_nxt.status[ocpi_pkg::STS_DIAG_BIT] = st_diag;
      st_nxt.status[ocpi_pkg::STS_TXVALID_BIT] = st_nxt.tx_valid;
      st_nxt.status[ocpi_pkg::STS_CNT_LO_BIT +: 2] = st_nxt.cycle_cnt;
      st_nxt.status[ocpi_pkg::STS_ERROR_BIT] = st_error;
      st_nxt.status[ocpi_pkg::STS_RST_MIRROR_BIT] = st_nxt.rst_latch;
      st_nxt.status[ocpi_pkg::STS_ON_MIRROR_BIT] = st_nxt.on_latch;
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         st_r <= '0;
         st_r.out_assign <= ocpi_pkg::OCPI_CMD_IMAGE_IDX;
         st_r.in_assign <= ocpi_pkg::OCPI_STS_IMAGE_IDX;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign status_image = st_r.status;
   assign out_assign = st_r.out_assign;
   assign in_assign = st_r.in_assign;
   assign channel_turn_on_pulse = st_r.on_pulse;
   assign channel_reset_pulse = st_r.rst_pulse;

   property p_on_edge;
      @(posedge clock) disable iff (reset)
         (link_running && cmd_valid && cmd_image[ocpi_pkg::CMD_ON_BIT]
          && !status_image[ocpi_pkg::STS_ON_MIRROR_BIT]) |=> channel_turn_on_pulse;
   endproperty
   a_on_edge: assert property (p_on_edge) else $error("missed turn-on edge");

   property p_rst_edge;
      @(posedge clock) disable iff (reset)
         (link_running && cmd_valid && cmd_image[ocpi_pkg::CMD_RESET_BIT]
          && !status_image[ocpi_pkg::STS_RST_MIRROR_BIT]) |=> channel_reset_pulse;
   endproperty
   a_rst_edge: assert property (p_rst_edge) else $error("missed reset edge");

   property p_on_single;
      @(posedge clock) disable iff (reset)
         channel_turn_on_pulse |=> !channel_turn_on_pulse;
   endproperty
   a_on_single: assert property (p_on_single) else $error("turn-on pulse too long");

   property p_mirror;
      @(posedge clock) disable iff (reset)
         (link_running && cmd_valid) |=> status_image[ocpi_pkg::STS_ON_MIRROR_BIT]
            == $past(cmd_image[ocpi_pkg::CMD_ON_BIT]);
   endproperty
   a_mirror: assert property (p_mirror) else $error("switch mirror wrong");

   property p_rmirror;
      @(posedge clock) disable iff (reset)
         (link_running && cmd_valid) |=> status_image[ocpi_pkg::STS_RST_MIRROR_BIT]
            == $past(cmd_image[ocpi_pkg::CMD_RESET_BIT]);
   endproperty
   a_rmirror: assert property (p_rmirror) else $error("reset mirror wrong");

   property p_pad;
      @(posedge clock) disable iff (reset)
         (status_image & OCPI_STS_PAD_MASK) == ocpi_pkg::OCPI_STS_RESET_VAL;
   endproperty
   a_pad: assert property (p_pad) else $error("status padding nonzero");

   property p_map_hold;
      @(posedge clock) disable iff (reset)
         link_running |=> $stable(out_assign) && $stable(in_assign);
   endproperty
   a_map_hold: assert property (p_map_hold) else $error("mapping changed while running");

   sequence s_cycle;
      link_running && cmd_valid;
   endsequence
   property p_cnt;
      @(posedge clock) disable iff (reset)
         s_cycle ##1 s_cycle |=> status_image[ocpi_pkg::STS_CNT_LO_BIT +: 2]
            == $past(status_image[ocpi_pkg::STS_CNT_LO_BIT +: 2], 2) + 2'h2;
   endproperty
   a_cnt: assert property (p_cnt) else $error("cycle counter wrong");

   property p_cnt_step;
      @(posedge clock) disable iff (reset)
         s_cycle |=> status_image[ocpi_pkg::STS_CNT_LO_BIT +: 2]
            == $past(status_image[ocpi_pkg::STS_CNT_LO_BIT +: 2]) + ocpi_pkg::OCPI_CNT_ONE;
   endproperty
   a_cnt_step: assert property (p_cnt_step) else $error("counter missed a word");

   property p_cnt_idle;
      @(posedge clock) disable iff (reset)
         !(link_running && cmd_valid)
            |=> $stable(status_image[ocpi_pkg::STS_CNT_LO_BIT +: 2]);
   endproperty
   a_cnt_idle: assert property (p_cnt_idle) else $error("counter moved without word");

   // object-valid flag set by a word
   property p_tx_set;
      @(posedge clock) disable iff (reset)
         s_cycle |=> status_image[ocpi_pkg::STS_TXVALID_BIT];
   endproperty
   a_tx_set: assert property (p_tx_set) else $error("object-valid flag not set");

   property p_tx_clear;
      @(posedge clock) disable iff (reset)
         !link_running |=> !status_image[ocpi_pkg::STS_TXVALID_BIT];
   endproperty
   a_tx_clear: assert property (p_tx_clear) else $error("object-valid flag stuck");

   // flags follow the core one cycle late
   property p_flags;
      @(posedge clock) disable iff (reset)
         1'b1 |=> status_image[ocpi_pkg::STS_ENABLED_BIT] == $past(st_enabled)
            && status_image[ocpi_pkg::STS_TRIPPED_BIT] == $past(st_tripped)
            && status_image[ocpi_pkg::STS_HWPROT_BIT] == $past(st_hw_protection)
            && status_image[ocpi_pkg::STS_WARN_BIT] == $past(st_current_warning)
            && status_image[ocpi_pkg::STS_COOL_BIT] == $past(st_cool_down_lock)
            && status_image[ocpi_pkg::STS_DIAG_BIT] == $past(st_diag)
            && status_image[ocpi_pkg::STS_ERROR_BIT] == $past(st_error);
   endproperty
   a_flags: assert property (p_flags) else $error("status flag misplaced");

   property p_rst_single;
      @(posedge clock) disable iff (reset)
         channel_reset_pulse |=> !channel_reset_pulse;
   endproperty
   a_rst_single: assert property (p_rst_single) else $error("reset pulse too long");

   // turn-on pulse only after a fresh edge
   property p_on_cause;
      @(posedge clock) disable iff (reset)
         channel_turn_on_pulse |-> $past(link_running && cmd_valid
            && cmd_image[ocpi_pkg::CMD_ON_BIT]
            && !status_image[ocpi_pkg::STS_ON_MIRROR_BIT]);
   endproperty
   a_on_cause: assert property (p_on_cause) else $error("turn-on pulse without edge");

   // reset pulse only after a fresh edge
   property p_rst_cause;
      @(posedge clock) disable iff (reset)
         channel_reset_pulse |-> $past(link_running && cmd_valid
            && cmd_image[ocpi_pkg::CMD_RESET_BIT]
            && !status_image[ocpi_pkg::STS_RST_MIRROR_BIT]);
   endproperty
   a_rst_cause: assert property (p_rst_cause) else $error("reset pulse without edge");

   // words refused while the link is stopped
   property p_refused;
      @(posedge clock) disable iff (reset)
         !link_running |=> !channel_turn_on_pulse && !channel_reset_pulse
            && $stable(status_image[ocpi_pkg::STS_ON_MIRROR_BIT])
            && $stable(status_image[ocpi_pkg::STS_RST_MIRROR_BIT]);
   endproperty
   a_refused: assert property (p_refused) else $error("word taken while stopped");

   property p_default_map;
      @(posedge clock)
         reset |=> out_assign == ocpi_pkg::OCPI_CMD_IMAGE_IDX
            && in_assign == ocpi_pkg::OCPI_STS_IMAGE_IDX;
   endproperty
   a_default_map: assert property (p_default_map) else $error("default mapping lost");
endmodule

/* File: design/ocpi_pkg.sv */
// Constants for the overcurrent channel process image.
// Assumes one 20 MHz clock shared by the whole image logic.
package ocpi_pkg;
   localparam logic [15:0] OCPI_CMD_IMAGE_IDX = 16'h1600;
   localparam logic [15:0] OCPI_STS_IMAGE_IDX = 16'h1A00;
   localparam logic [15:0] OCPI_OUT_ASSIGN_IDX = 16'h1C12;
   localparam logic [15:0] OCPI_IN_ASSIGN_IDX = 16'h1C13;
   localparam int OCPI_CMD_W = 16;
   localparam int OCPI_STS_W = 32;
   localparam int CMD_RESET_BIT = 0;
   localparam int CMD_ON_BIT = 1;
   localparam int STS_ENABLED_BIT = 0;
   localparam int STS_TRIPPED_BIT = 1;
   localparam int STS_HWPROT_BIT = 4;
   localparam int STS_WARN_BIT = 7;
   localparam int STS_COOL_BIT = 8;
   localparam int STS_DIAG_BIT = 12;
   localparam int STS_TXVALID_BIT = 13;
   localparam int STS_CNT_LO_BIT = 14;
   localparam int STS_ERROR_BIT = 18;
   localparam int STS_RST_MIRROR_BIT = 19;
   localparam int STS_ON_MIRROR_BIT = 20;
   localparam logic [1:0] OCPI_CNT_ONE = 2'h1;
   localparam logic [15:0] OCPI_CMD_RESET_VAL = 16'h0000;
   localparam logic [31:0] OCPI_STS_RESET_VAL = 32'h0000_0000;
endpackage

/* File: sim/ocpi_master_model.sv */
// Fieldbus master model driving the command word of one channel.
// Assumes status_image is registered and valid one cycle after a word.
module ocpi_master_model (
   input wire logic clock,
   input wire logic [31:0] status_image,
   output logic cmd_valid,
   output logic [15:0] cmd_image
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      cmd_valid = 1'b0;
      cmd_image = 16'hFFFC;
   end
   // padding sent as ones on purpose
   task automatic handshake(input int b, input int m, output int ok);
      int n;
      int up;
      ok = 0;
      @(negedge clock);
      cmd_valid = 1'b1;
      cmd_image = 16'hFFFC | (16'h0001 << b);
      for (n = 0; n < 20 && status_image[m] !== 1'b1; n++) @(negedge clock);
      up = int'(status_image[m] === 1'b1);
      cmd_image = 16'hFFFC;
      for (n = 0; n < 20 && status_image[m] !== 1'b0; n++) @(negedge clock);
      cmd_valid = 1'b0;
      // Both phases must have been confirmed, not just timed out
      ok = up & int'(status_image[m] === 1'b0);
   endtask
   task automatic word(input logic [15:0] w);
      @(negedge clock);
      cmd_valid = 1'b1;
      cmd_image = w;
      @(negedge clock);
      cmd_valid = 1'b0;
   endtask
endmodule

/* File: sim/overcurrent_channel_process_image_tb.sv */
// Self-checking bench for the channel process image.
// Assumes ocpi_master_model as the only command source.
module overcurrent_channel_process_image_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock = 0, reset = 1, link_running = 0, cmd_valid, on_p, rst_p;
   logic [15:0] cmd_image, out_req = 16'h1600, in_req = 16'h1A00, out_assign, in_assign;
   logic [6:0] st = '0;
   logic [31:0] status_image;
   // Expected status word for each single core flag, in st order
   logic [31:0] flag_pos [7] = '{32'h0000_0001, 32'h0000_0002, 32'h0000_0010, 32'h0000_0080,
      32'h0000_0100, 32'h0000_1000, 32'h0004_0000};
   int mismatches = 0, total_checks = 0, n_on, n_rst, taken = 0, cyc = 0, ok;
   always #25 clock = ~clock;
   ocpi_channel_image i_dut (.clock, .reset, .link_running, .cmd_valid, .cmd_image,
      .out_assign_req(out_req), .in_assign_req(in_req), .st_enabled(st[0]),
      .st_tripped(st[1]), .st_hw_protection(st[2]), .st_current_warning(st[3]),
      .st_cool_down_lock(st[4]), .st_diag(st[5]), .st_error(st[6]), .status_image,
      .out_assign, .in_assign, .channel_turn_on_pulse(on_p), .channel_reset_pulse(rst_p));
   ocpi_master_model i_master (.clock, .status_image, .cmd_valid, .cmd_image);
   always @(posedge clock) begin
      cyc++;
      if (on_p === 1'b1) n_on++;
      if (rst_p === 1'b1) n_rst++;
      if (link_running && cmd_valid) taken++;
      if (cyc > 3000) begin
         mismatches++;
         wrap_up;
      end
   end
   task check(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task wrap_up;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task t_flags;
      int i;
      @(negedge clock);
      // One flag at a time so a swapped position shows up
      for (i = 0; i < 7; i++) begin
         st = 7'h01 << i;
         repeat (2) @(negedge clock);
         check(status_image, flag_pos[i]);
      end
      st = '1;
      repeat (2) @(negedge clock);
      check(status_image, 32'h0004_1193);
      st = '0;
      $display("flags done");
   endtask
   task t_hs(input int b, input int m);
      n_on = 0;
      n_rst = 0;
      i_master.handshake(b, m, ok);
      repeat (2) @(negedge clock);
      check(ok, 1);
      check(n_on, b);
      check(n_rst, 1 - b);
      check(status_image[15:14], taken % 4);
      check(status_image[13], 1);
      check(status_image[20:19], 2'h0);
      $display("handshake %0d done", b);
   endtask
   task t_map;
      out_req = 16'h1601;
      in_req = 16'h1A01;
      repeat (2) @(negedge clock);
      check(out_assign, 16'h1600);
      check(in_assign, 16'h1A00);
      link_running = 0;
      n_on = 0;
      i_master.word(16'h0002);
      repeat (2) @(negedge clock);
      check(n_on, 0);
      check(status_image[13], 0);
      check(status_image[20:19], 2'h0);
      check(out_assign, 16'h1601);
      check(in_assign, 16'h1A01);
      link_running = 1;
      out_req = 16'h1602;
      repeat (2) @(negedge clock);
      check(out_assign, 16'h1601);
      $display("mapping done");
   endtask
   task t_rst;
      @(negedge clock);
      reset = 1;
      link_running = 0;
      repeat (2) @(negedge clock);
      reset = 0;
      link_running = 1;
      check(out_assign, 16'h1600);
      check(in_assign, 16'h1A00);
      check(status_image, 32'h0000_0000);
      repeat (2) @(negedge clock);
      check(out_assign, 16'h1600);
      $display("reset done");
   endtask
   initial begin
      repeat (6) @(negedge clock);
      reset = 0;
      link_running = 1;
      check(out_assign, 16'h1600);
      check(in_assign, 16'h1A00);
      check(status_image, 0);
      t_flags;
      t_hs(1, 20);
      t_hs(0, 19);
      t_map;
      t_rst;
      wrap_up;
   end
endmodule
